// File: charger_control_config_regs.sv
`timescale 1ns/1ps
module charger_control_config_regs #(
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] CMP_DB_2MS_US = 23'h0007d0,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] CMP_DB_5S_US = 23'h4c4b40,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] LONG_DB_1P3S_US = 23'h13d620,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] SHORT_DB_150MS_US = 23'h0249f0,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] HOLD_20MS_US = 23'h004e20,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] HOLD_15MS_US = 23'h003a98,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] HOLD_10MS_US = 23'h002710,
	parameter logic [charger_ctrl_pkg::CNT_W-1:0] HOLD_5MS_US = 23'h001388
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// register access, command code addressed
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_cmd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// power stage status
	input wire logic comparator_raw_in,
	input wire logic battery_absent_pin_in,
	input wire logic vbat_below_min_in,
	input wire logic turbo_mode_in,
	input wire logic adapter_inserted_in,
	input wire logic single_cell_in,
	input wire logic adapter_current_alert_in,
	input wire logic discharge_current_alert_in,
	input wire logic low_system_voltage_alert_in,
	// power stage controls
	output logic comparator_asserted_out,
	output logic learn_mode_out,
	output logic reverse_output_on_out,
	output logic audio_filter_en_out,
	output logic [1:0] freq_override_out,
	output logic battery_gate_fet_on_out,
	output logic current_monitor_en_out,
	output logic monitor_select_battery_out,
	output logic system_power_monitor_en_out,
	output logic switching_en_out,
	output logic [7:0] low_voltage_threshold_out,
	output logic [9:0] trickle_current_ma_out,
	output logic two_level_limit_en_out,
	output logic adapter_present_flag_out,
	output logic adapter_input_switch_on_out,
	output logic processor_hot_alert_out
);
	localparam int W = charger_ctrl_pkg::CNT_W;

	// ---------------------------------------------------------------
	// decode functions
	// ---------------------------------------------------------------
	function automatic logic [W-1:0] long_or_short(input logic short_sel);
		return short_sel ? SHORT_DB_150MS_US : LONG_DB_1P3S_US;
	endfunction

	function automatic logic [W-1:0] cmp_db(input logic [1:0] code);
		unique case (code)
			2'h0: return charger_ctrl_pkg::CMP_DB_2US;
			2'h1: return charger_ctrl_pkg::CMP_DB_12US;
			2'h2: return CMP_DB_2MS_US;
			2'h3: return CMP_DB_5S_US;
		endcase
	endfunction

	function automatic logic [W-1:0] alert_db(input logic [1:0] code);
		unique case (code)
			2'h0: return charger_ctrl_pkg::ALERT_DB_7US;
			2'h1: return charger_ctrl_pkg::ALERT_DB_100US;
			2'h2: return charger_ctrl_pkg::ALERT_DB_500US;
			2'h3: return charger_ctrl_pkg::ALERT_DB_1MS;
		endcase
	endfunction

	function automatic logic [W-1:0] hold_time(input logic [2:0] code);
		unique case (code)
			3'h0: return HOLD_10MS_US;
			3'h1: return HOLD_20MS_US;
			3'h2: return HOLD_15MS_US;
			3'h3: return HOLD_5MS_US;
			3'h4: return charger_ctrl_pkg::HOLD_1MS;
			3'h5: return charger_ctrl_pkg::HOLD_500US;
			3'h6: return charger_ctrl_pkg::HOLD_100US;
			3'h7: return charger_ctrl_pkg::HOLD_0S;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [15:0] ctrl_one_ff;
	logic [15:0] ctrl_two_ff;
	logic hit_one;
	logic hit_two;
	logic [15:0] nxt_rdata;

	assign hit_one = (reg_cmd_in == charger_ctrl_pkg::CTRL_ONE_ADDR);
	assign hit_two = (reg_cmd_in == charger_ctrl_pkg::CTRL_TWO_ADDR);
	// unmapped codes read as zero
	assign nxt_rdata = hit_one ? ctrl_one_ff
		: (hit_two ? ctrl_two_ff : 16'h0000);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ctrl_one_ff <= charger_ctrl_pkg::CTRL_RESET;
			ctrl_two_ff <= charger_ctrl_pkg::CTRL_RESET;
			reg_rdata_out <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			// control one bit 7 and control two bits 4:0 are dropped, so host writes there are harmless
			if (reg_wr_in && hit_one)
				ctrl_one_ff <= reg_wdata_in & charger_ctrl_pkg::CTRL_ONE_MASK;
			if (reg_wr_in && hit_two)
				ctrl_two_ff <= reg_wdata_in & charger_ctrl_pkg::CTRL_TWO_MASK;
			reg_rdata_out <= reg_rd_in ? nxt_rdata : 16'h0000;
			reg_rvalid_out <= reg_rd_in;
		end
	end

	// ---------------------------------------------------------------
	// field wires
	// ---------------------------------------------------------------
	logic [1:0] cmp_code;
	logic [1:0] alert_code;
	logic [2:0] hold_code;
	logic [1:0] lowv_code;
	logic [1:0] trickle_code;
	logic reverse_req;
	logic reverse_mode;

	assign cmp_code = ctrl_one_ff[charger_ctrl_pkg::C1_CMP_DB_HI:charger_ctrl_pkg::C1_CMP_DB_LO];
	assign alert_code = ctrl_two_ff[charger_ctrl_pkg::C2_ALERT_DB_HI:charger_ctrl_pkg::C2_ALERT_DB_LO];
	assign hold_code = ctrl_two_ff[charger_ctrl_pkg::C2_HOLD_HI:charger_ctrl_pkg::C2_HOLD_LO];
	assign lowv_code = ctrl_one_ff[charger_ctrl_pkg::C1_LOWV_HI:charger_ctrl_pkg::C1_LOWV_LO];
	assign trickle_code = ctrl_two_ff[charger_ctrl_pkg::C2_TRICKLE_HI:charger_ctrl_pkg::C2_TRICKLE_LO];
	assign reverse_req = ctrl_one_ff[charger_ctrl_pkg::C1_REVERSE_EN];

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------
	logic tick;
	logic cmp_stable;
	logic reverse_stable;
	logic adapter_stable;
	logic curr_alert_stable;
	logic lowv_alert_stable;
	logic switch_was_off_ff;
	logic [W-1:0] adapter_db;
	logic [W-1:0] reverse_db;

	// shared 1 us tick: debounces may run up to a tick short
	us_tick_gen u_tick (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_out(tick)
	);

	assert_debouncer u_cmp_db (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.limit_in(cmp_db(cmp_code)),
		.raw_in(comparator_raw_in),
		.stable_out(cmp_stable)
	);

	// enable waits the debounce, disable acts at once
	assign reverse_db = long_or_short(ctrl_two_ff[charger_ctrl_pkg::C2_REV_DB_SHORT]);
	assert_debouncer u_rev_db (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.limit_in(reverse_db),
		.raw_in(reverse_req),
		.stable_out(reverse_stable)
	);

	// first insertion since reset is fixed short until the switch has opened once
	assign adapter_db = switch_was_off_ff ? long_or_short(ctrl_two_ff[charger_ctrl_pkg::C2_ADP_DB_SHORT])
		: SHORT_DB_150MS_US;

	assert_debouncer u_adp_db (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.limit_in(adapter_db),
		.raw_in(adapter_inserted_in),
		.stable_out(adapter_stable)
	);

	assert_debouncer u_curr_db (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.limit_in(alert_db(alert_code)),
		.raw_in(adapter_current_alert_in | discharge_current_alert_in),
		.stable_out(curr_alert_stable)
	);

	assert_debouncer u_lowv_db (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.limit_in(charger_ctrl_pkg::LOWV_DB_10US),
		.raw_in(low_system_voltage_alert_in),
		.stable_out(lowv_alert_stable)
	);

	// ---------------------------------------------------------------
	// learn mode and alert hold
	// ---------------------------------------------------------------
	logic learn_exited_ff;
	logic learn_req;
	logic [W-1:0] hold_ff;
	logic alert_src;
	logic alert_now;
	logic nxt_switch;

	assign learn_req = ctrl_one_ff[charger_ctrl_pkg::C1_LEARN_EN] && !battery_absent_pin_in;
	// any debounced source reloads the hold
	assign alert_src = curr_alert_stable | lowv_alert_stable;
	assign alert_now = alert_src || (hold_ff != '0);
	assign reverse_mode = reverse_stable;
	// outside reverse mode the switch follows the adapter
	assign nxt_switch = reverse_mode ? !ctrl_two_ff[charger_ctrl_pkg::C2_SWITCH_OFF]
		: adapter_stable;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			learn_exited_ff <= 1'b0;
			hold_ff <= '0;
			switch_was_off_ff <= 1'b0;
		end else begin
			// exit sticks until learn is disabled and re-enabled
			if (!ctrl_one_ff[charger_ctrl_pkg::C1_LEARN_EN])
				learn_exited_ff <= 1'b0;
			else if (ctrl_one_ff[charger_ctrl_pkg::C1_LEARN_EXIT] && vbat_below_min_in)
				learn_exited_ff <= 1'b1;
			if (alert_src)
				hold_ff <= hold_time(hold_code);
			else if (tick && hold_ff != '0)
				hold_ff <= hold_ff - 1'b1;
			if (adapter_input_switch_on_out && !nxt_switch)
				switch_was_off_ff <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	logic [7:0] nxt_lowv;
	logic [9:0] nxt_trickle;

	assign nxt_lowv = single_cell_in ? charger_ctrl_pkg::LOWV_1CELL :
		(lowv_code == 2'h0) ? charger_ctrl_pkg::LOWV_6V0 :
		(lowv_code == 2'h1) ? charger_ctrl_pkg::LOWV_6V3 :
		(lowv_code == 2'h2) ? charger_ctrl_pkg::LOWV_6V6 : charger_ctrl_pkg::LOWV_6V9;
	assign nxt_trickle = (trickle_code == 2'h0) ? charger_ctrl_pkg::TRICKLE_256 :
		(trickle_code == 2'h1) ? charger_ctrl_pkg::TRICKLE_128 :
		(trickle_code == 2'h2) ? charger_ctrl_pkg::TRICKLE_64 : charger_ctrl_pkg::TRICKLE_512;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			comparator_asserted_out <= 1'b0;
			learn_mode_out <= 1'b0;
			reverse_output_on_out <= 1'b0;
			audio_filter_en_out <= 1'b0;
			freq_override_out <= 2'h0;
			battery_gate_fet_on_out <= 1'b0;
			current_monitor_en_out <= 1'b1;
			monitor_select_battery_out <= 1'b0;
			system_power_monitor_en_out <= 1'b0;
			switching_en_out <= 1'b1;
			low_voltage_threshold_out <= charger_ctrl_pkg::LOWV_6V0;
			trickle_current_ma_out <= charger_ctrl_pkg::TRICKLE_256;
			two_level_limit_en_out <= 1'b0;
			adapter_present_flag_out <= 1'b0;
			adapter_input_switch_on_out <= 1'b0;
			processor_hot_alert_out <= 1'b0;
		end else begin
			comparator_asserted_out <= cmp_stable;
			learn_mode_out <= learn_req && !learn_exited_ff;
			reverse_output_on_out <= reverse_stable;
			audio_filter_en_out <= ctrl_one_ff[charger_ctrl_pkg::C1_AUDIO];
			freq_override_out <= ctrl_one_ff[charger_ctrl_pkg::C1_FREQ_HI:charger_ctrl_pkg::C1_FREQ_LO];
			battery_gate_fet_on_out <= (!ctrl_one_ff[charger_ctrl_pkg::C1_TURBO_DIS] && turbo_mode_in)
				|| ctrl_one_ff[charger_ctrl_pkg::C1_OUT_DIS];
			current_monitor_en_out <= adapter_stable
				|| !ctrl_one_ff[charger_ctrl_pkg::C1_MON_DIS];
			monitor_select_battery_out <= ctrl_one_ff[charger_ctrl_pkg::C1_MON_SEL];
			system_power_monitor_en_out <= ctrl_one_ff[charger_ctrl_pkg::C1_PWR_MON];
			switching_en_out <= !ctrl_one_ff[charger_ctrl_pkg::C1_OUT_DIS];
			low_voltage_threshold_out <= nxt_lowv;
			trickle_current_ma_out <= nxt_trickle;
			two_level_limit_en_out <= ctrl_two_ff[charger_ctrl_pkg::C2_TWO_LEVEL];
			adapter_present_flag_out <= adapter_stable;
			adapter_input_switch_on_out <= nxt_switch;
			processor_hot_alert_out <= alert_now;
		end
	end
endmodule // charger_control_config_regs

// File: charger_ctrl_pkg.sv
// Behaviour
// - comparator assertion debounce: 2us, 12us, 2ms, 5s
// - bit 13 lets low battery end learn
// - learn mode only with battery present
// - bit 11 enables reverse output
// - bit 10 enables audio filter
// - bits 9:8 override switching frequency
// - turbo enabled when bit 6 clear
// - monitor disable only without adapter
// - bit 4 picks battery monitor
// - bit 3 enables system power monitor
// - bit 2 stops switching, gate on
// - low voltage alert threshold, single cell fixed
// - bits 15:14 set trickle current
// - reverse enable debounced 1.3s or 150ms
// - bit 12 enables two-level input limit
// - adapter flag debounce 1.3s or 150ms
// - first insertion always uses 150ms; here only while the input switch has not yet opened since reset
// - alert debounce selectable; low voltage 10us
// - alert held for selected minimum time
// - reverse mode input switch by bit 5
package charger_ctrl_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_ONE_ADDR = 8'h3c;
	localparam logic [7:0] CTRL_TWO_ADDR = 8'h3d;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_ONE_MASK = 16'hff7f;
	localparam logic [15:0] CTRL_TWO_MASK = 16'hffe0;

	// ---------------------------------------------------------------
	// control one fields
	// ---------------------------------------------------------------
	localparam int C1_CMP_DB_HI = 15;
	localparam int C1_CMP_DB_LO = 14;
	localparam int C1_LEARN_EXIT = 13;
	localparam int C1_LEARN_EN = 12;
	localparam int C1_REVERSE_EN = 11;
	localparam int C1_AUDIO = 10;
	localparam int C1_FREQ_HI = 9;
	localparam int C1_FREQ_LO = 8;
	localparam int C1_TURBO_DIS = 6;
	localparam int C1_MON_DIS = 5;
	localparam int C1_MON_SEL = 4;
	localparam int C1_PWR_MON = 3;
	localparam int C1_OUT_DIS = 2;
	localparam int C1_LOWV_HI = 1;
	localparam int C1_LOWV_LO = 0;

	// ---------------------------------------------------------------
	// control two fields
	// ---------------------------------------------------------------
	localparam int C2_TRICKLE_HI = 15;
	localparam int C2_TRICKLE_LO = 14;
	localparam int C2_REV_DB_SHORT = 13;
	localparam int C2_TWO_LEVEL = 12;
	localparam int C2_ADP_DB_SHORT = 11;
	localparam int C2_ALERT_DB_HI = 10;
	localparam int C2_ALERT_DB_LO = 9;
	localparam int C2_HOLD_HI = 8;
	localparam int C2_HOLD_LO = 6;
	localparam int C2_SWITCH_OFF = 5;

	// ---------------------------------------------------------------
	// timing: one microsecond tick
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_NS / 1000;
	localparam int TICK_W = 4;
	localparam int CNT_W = 23;

	localparam logic [CNT_W-1:0] CMP_DB_2US = 23'h000002;
	localparam logic [CNT_W-1:0] CMP_DB_12US = 23'h00000c;
	localparam logic [CNT_W-1:0] ALERT_DB_7US = 23'h000007;
	localparam logic [CNT_W-1:0] ALERT_DB_100US = 23'h000064;
	localparam logic [CNT_W-1:0] ALERT_DB_500US = 23'h0001f4;
	localparam logic [CNT_W-1:0] ALERT_DB_1MS = 23'h0003e8;
	localparam logic [CNT_W-1:0] LOWV_DB_10US = 23'h00000a;
	localparam logic [CNT_W-1:0] HOLD_1MS = 23'h0003e8;
	localparam logic [CNT_W-1:0] HOLD_500US = 23'h0001f4;
	localparam logic [CNT_W-1:0] HOLD_100US = 23'h000064;
	localparam logic [CNT_W-1:0] HOLD_0S = 23'h000000;

	// ---------------------------------------------------------------
	// decoded analog settings
	// ---------------------------------------------------------------
	localparam logic [7:0] LOWV_6V0 = 8'h3c;
	localparam logic [7:0] LOWV_6V3 = 8'h3f;
	localparam logic [7:0] LOWV_6V6 = 8'h42;
	localparam logic [7:0] LOWV_6V9 = 8'h45;
	localparam logic [7:0] LOWV_1CELL = 8'h18;
	localparam logic [9:0] TRICKLE_256 = 10'h100;
	localparam logic [9:0] TRICKLE_128 = 10'h080;
	localparam logic [9:0] TRICKLE_64 = 10'h040;
	localparam logic [9:0] TRICKLE_512 = 10'h200;

endpackage

// File: us_tick_gen.sv
`timescale 1ns/1ps
module us_tick_gen (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// tick
	output logic tick_out
);
	logic [charger_ctrl_pkg::TICK_W-1:0] div_ff;
	logic wrap;

	assign wrap = (div_ff == charger_ctrl_pkg::TICK_W'(charger_ctrl_pkg::TICK_CYCLES - 1));

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			div_ff <= '0;
			tick_out <= 1'b0;
		end else begin
			div_ff <= wrap ? '0 : div_ff + 1'b1;
			tick_out <= wrap;
		end
	end
endmodule // us_tick_gen

// File: assert_debouncer.sv
`timescale 1ns/1ps
// output rises once raw has stayed high for limit ticks, falls at once
module assert_debouncer (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// timing
	input wire logic tick_in,
	input wire logic [charger_ctrl_pkg::CNT_W-1:0] limit_in,
	// signal
	input wire logic raw_in,
	output logic stable_out
);
	logic [charger_ctrl_pkg::CNT_W-1:0] cnt_ff;
	logic done;

	assign done = (cnt_ff >= limit_in);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !raw_in) begin
			cnt_ff <= '0;
			stable_out <= 1'b0;
		end else begin
			if (tick_in && !done)
				cnt_ff <= cnt_ff + 1'b1;
			stable_out <= done;
		end
	end
endmodule // assert_debouncer

// File: charger_control_config_regs_sva.sv
`timescale 1ns/1ps
module charger_control_config_regs_sva (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// register port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_cmd_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	// status
	input wire logic comparator_raw_in,
	input wire logic battery_absent_pin_in,
	input wire logic turbo_mode_in,
	input wire logic adapter_inserted_in,
	input wire logic single_cell_in,
	// controls
	input wire logic comparator_asserted_out,
	input wire logic learn_mode_out,
	input wire logic audio_filter_en_out,
	input wire logic [1:0] freq_override_out,
	input wire logic battery_gate_fet_on_out,
	input wire logic monitor_select_battery_out,
	input wire logic system_power_monitor_en_out,
	input wire logic switching_en_out,
	input wire logic [7:0] low_voltage_threshold_out,
	input wire logic [9:0] trickle_current_ma_out,
	input wire logic two_level_limit_en_out,
	input wire logic adapter_present_flag_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire c1_wr = reg_wr_in && reg_cmd_in == 8'h3c;
	wire c2_wr = reg_wr_in && reg_cmd_in == 8'h3d;
	// unused bits of each register must never leak out
	wire [15:0] live_mask = reg_cmd_in == 8'h3d ? 16'hffe0 : 16'hff7f;

	AST_RVALID: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
	AST_IDLE_RDATA: assert property (!reg_rvalid_out |-> reg_rdata_out == 16'h0000)
		else $error("read data not zero when idle");
	AST_UNUSED_ZERO: assert property (reg_rd_in |=> (reg_rdata_out & ~$past(live_mask)) == 16'h0000)
		else $error("unused bit reads one");
	AST_C1_FIELDS: assert property (c1_wr |-> ##2 {audio_filter_en_out, freq_override_out,
		monitor_select_battery_out, system_power_monitor_en_out} == $past({reg_wdata_in[10:8], reg_wdata_in[4:3]}, 2))
		else $error("control one fields wrong");
	AST_OUT_DISABLE: assert property (c1_wr && reg_wdata_in[2] |-> ##2 !switching_en_out && battery_gate_fet_on_out)
		else $error("output disable not applied");
	AST_TURBO_GATE: assert property (c1_wr && !reg_wdata_in[6] ##1 turbo_mode_in |=> battery_gate_fet_on_out)
		else $error("gate not on in turbo");
	AST_SINGLE_CELL: assert property (single_cell_in |=> low_voltage_threshold_out == charger_ctrl_pkg::LOWV_1CELL)
		else $error("single cell threshold wrong");
	AST_TRICKLE: assert property (c2_wr |-> ##2 trickle_current_ma_out == (($past(reg_wdata_in[15:14], 2) == 2'b11) ?
		10'h200 : (10'h100 >> $past(reg_wdata_in[15:14], 2)))) else $error("trickle current wrong");
	AST_TWO_LEVEL: assert property (c2_wr |-> ##2 two_level_limit_en_out == $past(reg_wdata_in[12], 2))
		else $error("two level enable wrong");
	AST_LEARN_PRESENT: assert property (battery_absent_pin_in |=> !learn_mode_out)
		else $error("learn mode without battery");
	AST_CMP_DEBOUNCE: assert property ($rose(comparator_asserted_out) |->
		$past(comparator_raw_in, 3) && $past(comparator_raw_in, 9)) else $error("comparator rose too early");
	AST_ADAPTER_DEBOUNCE: assert property ($rose(adapter_present_flag_out) |->
		$past(adapter_inserted_in, 3) && $past(adapter_inserted_in, 100)) else $error("adapter flag rose too early");
endmodule // charger_control_config_regs_sva
bind charger_control_config_regs charger_control_config_regs_sva u_sva (.*);

// File: smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
	// clock
	input wire logic clk_sys_in,
	// register port
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_cmd_out,
	output logic [15:0] reg_wdata_out
);
	logic [15:0] exp_q[$];
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_cmd_out = 8'h00;
		reg_wdata_out = 16'h0000;
	end
	// lines are scrambled after use so stale data never looks valid
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		@(negedge clk_sys_in);
		reg_cmd_out = cmd;
		reg_wdata_out = (cmd == charger_ctrl_pkg::CTRL_ONE_ADDR) ? (data & 16'hff7f) : data;
		reg_wr_out = 1'b1;
		@(negedge clk_sys_in);
		reg_wr_out = 1'b0;
		reg_wdata_out = ~reg_wdata_out;
		reg_cmd_out = ~cmd;
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [15:0] expect_data);
		@(negedge clk_sys_in);
		exp_q.push_back(expect_data);
		reg_cmd_out = cmd;
		reg_rd_out = 1'b1;
		@(negedge clk_sys_in);
		reg_rd_out = 1'b0;
		reg_cmd_out = ~cmd;
	endtask
endmodule // smbus_host_model

// File: charger_control_config_regs_bench.sv
`timescale 1ns/1ps
module charger_control_config_regs_bench;
	logic clk_sys_in, rst_in, comparator_raw_in, battery_absent_pin_in, vbat_below_min_in, turbo_mode_in;
	logic adapter_inserted_in, single_cell_in, adapter_current_alert_in, discharge_current_alert_in;
	logic low_system_voltage_alert_in, reg_wr_in, reg_rd_in, reg_rvalid_out, comparator_asserted_out;
	logic learn_mode_out, reverse_output_on_out, audio_filter_en_out, battery_gate_fet_on_out;
	logic current_monitor_en_out, monitor_select_battery_out, system_power_monitor_en_out, switching_en_out;
	logic two_level_limit_en_out, adapter_present_flag_out, adapter_input_switch_on_out, processor_hot_alert_out;
	logic [7:0] reg_cmd_in;
	logic [15:0] reg_wdata_in;
	logic [15:0] reg_rdata_out;
	logic [1:0] freq_override_out;
	logic [7:0] low_voltage_threshold_out;
	logic [9:0] trickle_current_ma_out;
	int mismatches = 0;
	int compares = 0;
	// long counts shrunk so the run stays short
	localparam logic [22:0] CMP_2MS = 23'h14;
	localparam logic [22:0] CMP_5S = 23'h32;
	localparam logic [22:0] DB_LONG = 23'h28;
	localparam logic [22:0] DB_SHORT = 23'hf;
	localparam logic [22:0] HOLD_20MS = 23'h8;
	localparam logic [22:0] HOLD_15MS = 23'h6;
	localparam logic [22:0] HOLD_10MS = 23'h5;
	localparam logic [22:0] HOLD_5MS = 23'h3;
	int cmp_us[4] = '{2, 12, CMP_2MS, CMP_5S};
	int alert_us[4] = '{7, 100, 500, 1000};
	int hold_us[8] = '{HOLD_10MS, HOLD_20MS, HOLD_15MS, HOLD_5MS, 1000, 500, 100, 0};

	smbus_host_model u_host (.clk_sys_in(clk_sys_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_cmd_out(reg_cmd_in), .reg_wdata_out(reg_wdata_in));
	charger_control_config_regs #(.CMP_DB_2MS_US(CMP_2MS), .CMP_DB_5S_US(CMP_5S), .LONG_DB_1P3S_US(DB_LONG),
		.SHORT_DB_150MS_US(DB_SHORT), .HOLD_20MS_US(HOLD_20MS), .HOLD_15MS_US(HOLD_15MS),
		.HOLD_10MS_US(HOLD_10MS), .HOLD_5MS_US(HOLD_5MS)) u_dut (.*);

	// ---------------------------------------------------------------
	// checking
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expect_val);
		compares++;
		if (seen !== expect_val) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, expect_val, seen);
		end
	endtask
	task automatic stop_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: return comparator_asserted_out;
			1: return reverse_output_on_out;
			2: return adapter_present_flag_out;
			3: return processor_hot_alert_out;
			4: return learn_mode_out;
			default: return adapter_input_switch_on_out;
		endcase
	endfunction
	task automatic lvl(input int k, input int cyc, input logic expect_bit);
		repeat (cyc) @(negedge clk_sys_in);
		check($sformatf("out%0d", k), 16'(pick(k)), 16'(expect_bit));
	endtask
	always @(negedge clk_sys_in) begin
		if (reg_rvalid_out === 1'b1) check("rdata", reg_rdata_out, u_host.exp_q.pop_front());
	end
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (80000) @(posedge clk_sys_in);
		mismatches++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		logic [15:0] c1, c2;
		int n;
		{comparator_raw_in, battery_absent_pin_in, vbat_below_min_in, turbo_mode_in, adapter_inserted_in} = 5'h00;
		{single_cell_in, adapter_current_alert_in, discharge_current_alert_in, low_system_voltage_alert_in} = 4'h0;
		rst_in = 1'b1;
		void'($urandom(75326));
		repeat (8) @(negedge clk_sys_in);
		rst_in = 1'b0;
		check("rst", 16'({current_monitor_en_out, switching_en_out, low_voltage_threshold_out}), 16'h33c);
		check("rst_trk", 16'(trickle_current_ma_out), 16'h100);
		u_host.rd(8'h3c, 16'h0000);
		u_host.rd(8'h3d, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			c1 = 16'($urandom()) & 16'hf7ff;
			c2 = 16'($urandom());
			{turbo_mode_in, single_cell_in, battery_absent_pin_in} = 3'($urandom());
			u_host.wr(8'h3c, c1);
			u_host.wr(8'h3d, c2);
			@(negedge clk_sys_in);
			check("c1out", 16'({audio_filter_en_out, freq_override_out, monitor_select_battery_out,
				system_power_monitor_en_out, switching_en_out, current_monitor_en_out, battery_gate_fet_on_out,
				learn_mode_out}), 16'({c1[10:8], c1[4:3], !c1[2], !c1[5], (!c1[6] & turbo_mode_in) | c1[2],
				c1[12] & !battery_absent_pin_in}));
			check("lowv", 16'(low_voltage_threshold_out), single_cell_in ? 16'h18 : 16'(8'h3c + 8'h03 * c1[1:0]));
			check("c2out", 16'({two_level_limit_en_out, trickle_current_ma_out}), 16'({c2[12],
				(c2[15:14] == 2'b11) ? 10'h200 : 10'h100 >> c2[15:14]}));
			u_host.rd(8'h3c, c1 & 16'hff7f);
			u_host.rd(8'h3d, c2 & 16'hffe0);
		end
		{turbo_mode_in, single_cell_in, battery_absent_pin_in} = 3'h0;
		u_host.wr(8'h3c, 16'h0000);
		u_host.wr(8'h3d, 16'h0000);
		u_host.wr(8'h3e, 16'hffff);
		u_host.rd(8'h3e, 16'h0000);
		u_host.rd(8'h3c, 16'h0000);
		u_host.rd(8'h3d, 16'h0000);
		// learn exit latches until learn is turned off
		u_host.wr(8'h3c, 16'h3000);
		lvl(4, 2, 1'b1);
		vbat_below_min_in = 1'b1;
		lvl(4, 3, 1'b0);
		vbat_below_min_in = 1'b0;
		lvl(4, 3, 1'b0);
		u_host.wr(8'h3c, 16'h0000);
		vbat_below_min_in = 1'b1;
		u_host.wr(8'h3c, 16'h1000);
		lvl(4, 2, 1'b1);
		battery_absent_pin_in = 1'b1;
		lvl(4, 2, 1'b0);
		{battery_absent_pin_in, vbat_below_min_in} = 2'h0;
		for (int i = 0; i < 4; i++) begin
			u_host.wr(8'h3c, 16'(i) << 14);
			comparator_raw_in = 1'b1;
			lvl(0, cmp_us[i] * 10 - 12, 1'b0);
			lvl(0, 32, 1'b1);
			comparator_raw_in = 1'b0;
			lvl(0, 3, 1'b0);
		end
		// adapter before reverse: the first switch turn-off arms the selectable delay
		u_host.wr(8'h3c, 16'h0020);
		for (int i = 0; i < 3; i++) begin
			u_host.wr(8'h3d, i == 2 ? 16'h0800 : 16'h0000);
			adapter_inserted_in = 1'b1;
			n = (i == 1) ? DB_LONG : DB_SHORT;
			lvl(2, n * 10 - 12, 1'b0);
			lvl(2, 32, 1'b1);
			lvl(5, 1, 1'b1);
			check("cmon", 16'(current_monitor_en_out), 16'h0001);
			adapter_inserted_in = 1'b0;
			lvl(2, 3, 1'b0);
		end
		for (int i = 0; i < 2; i++) begin
			u_host.wr(8'h3d, 16'(i) << 13);
			u_host.wr(8'h3c, 16'h0800);
			lvl(1, (i ? DB_SHORT : DB_LONG) * 10 - 12, 1'b0);
			lvl(1, 32, 1'b1);
			u_host.wr(8'h3d, (16'(i) << 13) | 16'h0020);
			lvl(5, 2, 1'b0);
			u_host.wr(8'h3d, 16'(i) << 13);
			lvl(5, 2, 1'b1);
			u_host.wr(8'h3c, 16'h0000);
			lvl(1, 2, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			u_host.wr(8'h3d, (16'(i) << 9) | 16'h01c0);
			{discharge_current_alert_in, adapter_current_alert_in} = i[0] ? 2'b10 : 2'b01;
			lvl(3, alert_us[i] * 10 - 12, 1'b0);
			lvl(3, 32, 1'b1);
			{discharge_current_alert_in, adapter_current_alert_in} = 2'b00;
			lvl(3, 12, 1'b0);
		end
		u_host.wr(8'h3d, 16'h07c0);
		low_system_voltage_alert_in = 1'b1;
		lvl(3, 88, 1'b0);
		lvl(3, 32, 1'b1);
		low_system_voltage_alert_in = 1'b0;
		lvl(3, 12, 1'b0);
		for (int i = 0; i < 8; i++) begin
			u_host.wr(8'h3d, 16'(i) << 6);
			low_system_voltage_alert_in = 1'b1;
			lvl(3, 120, 1'b1);
			low_system_voltage_alert_in = 1'b0;
			if (hold_us[i] > 0) lvl(3, hold_us[i] * 10 - 10, 1'b1);
			lvl(3, hold_us[i] > 0 ? 40 : 12, 1'b0);
		end
		repeat (4) @(negedge clk_sys_in);
		check("pending", 16'(u_host.exp_q.size()), 16'h0000);
		stop_test();
	end
endmodule // charger_control_config_regs_bench
